// file: rtl/ivd_defines.svh
// constants of the interrupt vector dispatch block: offsets, fields, indices, vectors
// assumes inclusion by bare name from the block's modules
`ifndef IVD_DEFINES_SVH
`define IVD_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define IVD_OFS_EN1 8'h00
`define IVD_OFS_EN2 8'h04
`define IVD_OFS_NMC 8'h08
`define IVD_OFS_PEND 8'h0c
`define IVD_OFS_ISTAT 8'h10
`define IVD_OFS_IMASK 8'h14
`define IVD_OFS_FDC 8'h18
`define IVD_OFS_VSTAT 8'h1c

// ----------------------------------------------------------------
// enable bit positions
// ----------------------------------------------------------------
`define IVD_EN1_EXT0 0
`define IVD_EN1_TMR0 1
`define IVD_EN1_EXT1 2
`define IVD_EN1_TMR1 3
`define IVD_EN1_ASER 4
`define IVD_EN1_TMR2G 5
`define IVD_EN2_CONV 0
`define IVD_EN2_SSER 1
`define IVD_EN2_EXT2 2
`define IVD_EN2_EXTG 3
`define IVD_EN2_CC0 4
`define IVD_NMC_BITS 6
`define IVD_EN1_BITS 6
`define IVD_EN2_BITS 8

// ----------------------------------------------------------------
// divider control fields and status bits
// ----------------------------------------------------------------
`define IVD_FDC_EN 0
`define IVD_FDC_NORMAL 1
`define IVD_FDC_OVF 2
`define IVD_FDC_STEP_LSB 8
`define IVD_ST_TAKEN 0
`define IVD_ST_OVERRUN 1
`define IVD_ST_DIVOVF 2
`define IVD_ST_BITS 3

// ----------------------------------------------------------------
// sources, vectors and reset values
// ----------------------------------------------------------------
`define IVD_NSRC 25
`define IVD_NVEC 15
`define IVD_SRC_FDOVF 12
`define IVD_VEC_NMI 0
`define IVD_VEC_T2G 6
`define IVD_VEC_EXTG 10
`define IVD_RST_BYTE 8'h00
`define IVD_ADDR_NMI 16'h0073
`define IVD_ADDR_EXT0 16'h0003
`define IVD_ADDR_TMR0 16'h000b
`define IVD_ADDR_EXT1 16'h0013
`define IVD_ADDR_TMR1 16'h001b
`define IVD_ADDR_ASER 16'h0023
`define IVD_ADDR_T2G 16'h002b
`define IVD_ADDR_CONV 16'h0033
`define IVD_ADDR_SSER 16'h003b
`define IVD_ADDR_EXT2 16'h0043
`define IVD_ADDR_EXTG 16'h004b
`define IVD_ADDR_CC0 16'h0053
`define IVD_ADDR_CC1 16'h005b
`define IVD_ADDR_CC2 16'h0063
`define IVD_ADDR_CC3 16'h006b

`endif

// file: rtl/ivd_pkg.sv
// types of the interrupt vector dispatch block
// assumes nothing from the defines header, which it does not include
package ivd_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOOKUP = 3'b010,
    ST_PRESENT = 3'b100
  } ivd_state_t;

  typedef struct packed {
    logic [7:0] step;
    logic ovf;
    logic normal;
    logic en;
  } ivd_fdc_t;

  typedef struct packed {
    logic req;
    logic [3:0] idx;
  } ivd_sel_t;

endpackage

// file: rtl/ivd_vec_table.sv
// fixed vector address table with registered read data
// assumes the index is held by the caller while the address is used
`timescale 1ns/1ps
`include "ivd_defines.svh"

module ivd_vec_table (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // lookup
  input wire logic [3:0] idx,
  output logic [15:0] addr_r
);

  logic [15:0] addr_nxt;

  always_comb
  begin
    case (idx)
      4'h0: addr_nxt = `IVD_ADDR_NMI;
      4'h1: addr_nxt = `IVD_ADDR_EXT0;
      4'h2: addr_nxt = `IVD_ADDR_TMR0;
      4'h3: addr_nxt = `IVD_ADDR_EXT1;
      4'h4: addr_nxt = `IVD_ADDR_TMR1;
      4'h5: addr_nxt = `IVD_ADDR_ASER;
      4'h6: addr_nxt = `IVD_ADDR_T2G;
      4'h7: addr_nxt = `IVD_ADDR_CONV;
      4'h8: addr_nxt = `IVD_ADDR_SSER;
      4'h9: addr_nxt = `IVD_ADDR_EXT2;
      4'ha: addr_nxt = `IVD_ADDR_EXTG;
      4'hb: addr_nxt = `IVD_ADDR_CC0;
      4'hc: addr_nxt = `IVD_ADDR_CC1;
      4'hd: addr_nxt = `IVD_ADDR_CC2;
      4'he: addr_nxt = `IVD_ADDR_CC3;
      default: addr_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      addr_r <= 16'h0000;
    else
      addr_r <= addr_nxt;
  end

endmodule

// file: rtl/ivd_top.sv
// interrupt source to vector dispatch with apb register access
// assumes request inputs are one-cycle pulses synchronous to pclk and the
// core answers a presented vector with a one-cycle acknowledge pulse
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`include "ivd_defines.svh"

module ivd_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_r,
  output logic pready_r,
  output logic pslverr_r,
  // peripheral requests
  input wire logic [`IVD_NSRC-1:0] src_req,
  // processor core
  output logic irq_req_r,
  output logic [15:0] irq_vector,
  input wire logic vec_ack,
  // interrupt to system
  output logic irq_out_r
);

  // ----------------------------------------------------------------
  // source to vector map
  // ----------------------------------------------------------------
  function automatic logic [3:0] src_vec(input int s);
    if (s <= 5) return 4'h0;
    else if (s <= 10) return 4'(s - 5);
    else if (s <= 13) return 4'h6;
    else if (s <= 16) return 4'(s - 7);
    else if (s <= 20) return 4'ha;
    else return 4'(s - 10);
  endfunction

  function automatic logic [`IVD_NSRC-1:0] vec_mask(input int v);
    logic [`IVD_NSRC-1:0] m;
    m = '0;
    for (int s = 0; s < `IVD_NSRC; s++)
      m[s] = (src_vec(s) == 4'(v));
    return m;
  endfunction

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic [`IVD_EN1_BITS-1:0] en1_r;
  logic [`IVD_EN2_BITS-1:0] en2_r;
  logic [`IVD_NMC_BITS-1:0] nmc_r;
  logic [`IVD_NSRC-1:0] pend_r;
  logic [`IVD_NSRC-1:0] pend_nxt;
  logic [`IVD_ST_BITS-1:0] stat_r;
  logic [`IVD_ST_BITS-1:0] stat_nxt;
  logic [`IVD_ST_BITS-1:0] mask_r;
  ivd_pkg::ivd_fdc_t fdc_r;
  ivd_pkg::ivd_fdc_t fdc_nxt;
  logic [7:0] fd_cnt_r;
  logic [7:0] fd_cnt_nxt;
  ivd_pkg::ivd_state_t state_r;
  ivd_pkg::ivd_state_t state_nxt;
  logic [3:0] cur_idx_r;
  logic [3:0] cur_idx_nxt;
  logic irq_req_nxt;
  ivd_pkg::ivd_sel_t sel;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire logic setup = psel & ~penable;
  wire logic wr_acc = psel & penable & pready_r & pwrite;
  wire logic hit_en1 = (paddr == `IVD_OFS_EN1);
  wire logic hit_en2 = (paddr == `IVD_OFS_EN2);
  wire logic hit_nmc = (paddr == `IVD_OFS_NMC);
  wire logic hit_pend = (paddr == `IVD_OFS_PEND);
  wire logic hit_istat = (paddr == `IVD_OFS_ISTAT);
  wire logic hit_imask = (paddr == `IVD_OFS_IMASK);
  wire logic hit_fdc = (paddr == `IVD_OFS_FDC);
  wire logic hit_vstat = (paddr == `IVD_OFS_VSTAT);
  wire logic hit_any = hit_en1 | hit_en2 | hit_nmc | hit_pend | hit_istat | hit_imask |
    hit_fdc | hit_vstat;
  // vector status is read only, so a write there is refused like an unmapped one
  wire logic bad_acc = ~hit_any | (pwrite & hit_vstat);
  wire logic wr_ok = wr_acc & ~bad_acc;

  wire logic [31:0] rd_mux =
    hit_en1 ? {26'h0, en1_r} :
    hit_en2 ? {24'h0, en2_r} :
    hit_nmc ? {26'h0, nmc_r} :
    hit_pend ? {7'h0, pend_r} :
    hit_istat ? {29'h0, stat_r} :
    hit_imask ? {29'h0, mask_r} :
    hit_fdc ? {16'h0, fdc_r.step, 5'h00, fdc_r.ovf, fdc_r.normal, fdc_r.en} :
    hit_vstat ? {9'h00, state_r, cur_idx_r, irq_vector} :
    32'h0000_0000;

  // ----------------------------------------------------------------
  // fractional divider in normal mode
  // ----------------------------------------------------------------
  wire logic fd_run = fdc_r.en & fdc_r.normal;
  wire logic fd_ovf = fd_run & (fd_cnt_r == 8'hff);
  wire logic fdc_ovf_clr = wr_ok & hit_fdc & pwdata[`IVD_FDC_OVF];

  // counts up from the step value at pclk rate, reloading on overflow; while stopped it
  // follows the step being written, so enabling and setting the step in one write starts
  // from the new step rather than a stale one
  assign fd_cnt_nxt = !fd_run ? fdc_nxt.step :
    (fd_ovf ? fdc_r.step : fd_cnt_r + 8'h01);

  always_comb
  begin
    fdc_nxt = fdc_r;
    if (wr_ok && hit_fdc)
    begin
      fdc_nxt.en = pwdata[`IVD_FDC_EN];
      fdc_nxt.normal = pwdata[`IVD_FDC_NORMAL];
      fdc_nxt.step = pwdata[`IVD_FDC_STEP_LSB +: 8];
    end
    // the overflow flag survives a clear that meets a new overflow
    fdc_nxt.ovf = (fdc_r.ovf & ~fdc_ovf_clr) | fd_ovf;
  end

  // ----------------------------------------------------------------
  // request capture and enable gating
  // ----------------------------------------------------------------
  logic [`IVD_NSRC-1:0] req_in;
  logic [`IVD_NSRC-1:0] en_src;
  logic [`IVD_NSRC-1:0] live;
  logic [`IVD_NSRC-1:0] ack_clr;
  logic [`IVD_NVEC-1:0] vec_act;

  assign req_in = src_req | (`IVD_NSRC'(fd_ovf) << `IVD_SRC_FDOVF);
  assign en_src[5:0] = nmc_r;
  assign en_src[6] = en1_r[`IVD_EN1_EXT0];
  assign en_src[7] = en1_r[`IVD_EN1_TMR0];
  assign en_src[8] = en1_r[`IVD_EN1_EXT1];
  assign en_src[9] = en1_r[`IVD_EN1_TMR1];
  assign en_src[10] = en1_r[`IVD_EN1_ASER];
  assign en_src[13:11] = {3{en1_r[`IVD_EN1_TMR2G]}};
  assign en_src[14] = en2_r[`IVD_EN2_CONV];
  assign en_src[15] = en2_r[`IVD_EN2_SSER];
  assign en_src[16] = en2_r[`IVD_EN2_EXT2];
  assign en_src[20:17] = {4{en2_r[`IVD_EN2_EXTG]}};
  assign en_src[24:21] = en2_r[`IVD_EN2_CC0 +: 4];
  assign live = pend_r & en_src;

  genvar gv;
  generate
    for (gv = 0; gv < `IVD_NVEC; gv++)
    begin : g_vec
      assign vec_act[gv] = |(live & vec_mask(gv));
    end
  endgenerate

  // fixed order: non-maskable first, then ascending vector address
  always_comb
  begin
    sel.req = 1'b0;
    sel.idx = 4'h0;
    for (int v = `IVD_NVEC - 1; v >= 0; v--)
      if (vec_act[v])
      begin
        sel.req = 1'b1;
        sel.idx = 4'(v);
      end
  end

  // shared vectors keep their flags so the handler can tell the origin
  wire logic cur_shared = (cur_idx_r == 4'(`IVD_VEC_NMI)) | (cur_idx_r == 4'(`IVD_VEC_T2G)) |
    (cur_idx_r == 4'(`IVD_VEC_EXTG));
  wire logic taken = (state_r == ivd_pkg::ST_PRESENT) & vec_ack;
  assign ack_clr = (taken & ~cur_shared) ? vec_mask(int'(cur_idx_r)) : '0;

  wire logic [`IVD_NSRC-1:0] sw_clr = (wr_ok & hit_pend) ? pwdata[`IVD_NSRC-1:0] : '0;
  assign pend_nxt = (pend_r & ~ack_clr & ~sw_clr) | req_in;

  // ----------------------------------------------------------------
  // dispatch sequence
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    cur_idx_nxt = cur_idx_r;
    irq_req_nxt = irq_req_r;
    case (state_r)
      ivd_pkg::ST_IDLE:
      begin
        if (sel.req)
        begin
          cur_idx_nxt = sel.idx;
          state_nxt = ivd_pkg::ST_LOOKUP;
        end
      end
      ivd_pkg::ST_LOOKUP:
      begin
        // one cycle for the table; abandon if the source went away meanwhile
        if (vec_act[cur_idx_r])
        begin
          state_nxt = ivd_pkg::ST_PRESENT;
          irq_req_nxt = 1'b1;
        end
        else
          state_nxt = ivd_pkg::ST_IDLE;
      end
      ivd_pkg::ST_PRESENT:
      begin
        if (vec_ack || !vec_act[cur_idx_r])
        begin
          state_nxt = ivd_pkg::ST_IDLE;
          irq_req_nxt = 1'b0;
        end
      end
      default:
      begin
        state_nxt = ivd_pkg::ST_IDLE;
        irq_req_nxt = 1'b0;
      end
    endcase
  end

  ivd_vec_table u_table (
    .pclk(pclk),
    .presetn(presetn),
    .idx(cur_idx_r),
    .addr_r(irq_vector)
  );

  // ----------------------------------------------------------------
  // interrupt status, set wins over write-one clear
  // ----------------------------------------------------------------
  logic [`IVD_ST_BITS-1:0] ev;
  assign ev[`IVD_ST_TAKEN] = taken;
  assign ev[`IVD_ST_OVERRUN] = |(req_in & pend_r);
  assign ev[`IVD_ST_DIVOVF] = fd_ovf;
  wire logic [`IVD_ST_BITS-1:0] st_clr = (wr_ok & hit_istat) ? pwdata[`IVD_ST_BITS-1:0] : '0;
  assign stat_nxt = (stat_r & ~st_clr) | ev;

  // ----------------------------------------------------------------
  // flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= setup;
      pslverr_r <= setup & bad_acc;
      prdata_r <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en1_r <= `IVD_EN1_BITS'(`IVD_RST_BYTE);
      en2_r <= `IVD_EN2_BITS'(`IVD_RST_BYTE);
      nmc_r <= `IVD_NMC_BITS'(`IVD_RST_BYTE);
      mask_r <= `IVD_ST_BITS'(`IVD_RST_BYTE);
    end
    else if (wr_ok)
    begin
      if (hit_en1)
        en1_r <= pwdata[`IVD_EN1_BITS-1:0];
      if (hit_en2)
        en2_r <= pwdata[`IVD_EN2_BITS-1:0];
      if (hit_nmc)
        nmc_r <= pwdata[`IVD_NMC_BITS-1:0];
      if (hit_imask)
        mask_r <= pwdata[`IVD_ST_BITS-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_r <= '0;
      stat_r <= '0;
      fdc_r <= '0;
      fd_cnt_r <= 8'h00;
      state_r <= ivd_pkg::ST_IDLE;
      cur_idx_r <= 4'h0;
      irq_req_r <= 1'b0;
      irq_out_r <= 1'b0;
    end
    else
    begin
      pend_r <= pend_nxt;
      stat_r <= stat_nxt;
      fdc_r <= fdc_nxt;
      fd_cnt_r <= fd_cnt_nxt;
      state_r <= state_nxt;
      cur_idx_r <= cur_idx_nxt;
      irq_req_r <= irq_req_nxt;
      irq_out_r <= |(stat_nxt & mask_r);
    end
  end

endmodule

// file: verification/ivd_top_sva.sv
// port assertions for the vector dispatch block
// assumes one clock domain and a bind onto ivd_top
`timescale 1ns/1ps
`include "ivd_defines.svh"
module ivd_top_sva (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata_r,
  input wire logic pready_r,
  input wire logic pslverr_r,
  // requests and core
  input wire logic [`IVD_NSRC-1:0] src_req,
  input wire logic irq_req_r,
  input wire logic [15:0] irq_vector,
  input wire logic vec_ack,
  input wire logic irq_out_r
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  setup_answer_a: assert property (psel && !penable |=> pready_r)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready_r |=> !pready_r)
    else $error("answer longer than one cycle");
  err_ready_a: assert property (pslverr_r |-> pready_r)
    else $error("error without answer");
  idle_rdata_a: assert property (!pready_r |-> prdata_r == 32'h0)
    else $error("read data outside access");
  unmapped_err_a: assert property (psel && !penable && paddr > 8'h1c |=> pslverr_r)
    else $error("unmapped access not refused");
  vstat_ro_a: assert property (psel && !penable && pwrite && paddr == 8'h1c |=> pslverr_r)
    else $error("read only write not refused");
  mapped_ok_a: assert property (psel && !penable && !pwrite && paddr[1:0] == 2'b00 &&
    paddr <= 8'h1c |=> !pslverr_r)
    else $error("mapped read refused");
  vec_legal_a: assert property (irq_req_r |-> irq_vector[2:0] == 3'h3 &&
    irq_vector <= 16'h0073)
    else $error("vector outside table");
  vec_hold_a: assert property (irq_req_r ##1 irq_req_r |-> $stable(irq_vector))
    else $error("vector changed while presented");
  ack_drop_a: assert property (irq_req_r && vec_ack |=> !irq_req_r [*2])
    else $error("request not dropped after ack");
endmodule
bind ivd_top ivd_top_sva sva_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
  .pready_r(pready_r), .pslverr_r(pslverr_r), .src_req(src_req), .irq_req_r(irq_req_r),
  .irq_vector(irq_vector), .vec_ack(vec_ack), .irq_out_r(irq_out_r));

// file: verification/ivd_core_model.sv
// behavioural processor core fetching presented vectors
// assumes the block holds irq_req_r until acknowledged or cleared
`timescale 1ns/1ps
module ivd_core_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // dispatch side
  input wire logic irq_req_r,
  input wire logic [15:0] irq_vector,
  output logic vec_ack,
  // bench side
  input wire logic [7:0] ack_wait,
  output logic vec_seen,
  output logic [15:0] vec_val
);
  logic [7:0] wait_r;
  // a slow core holds off the ack; a vanished request restarts the count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vec_ack <= 1'b0;
      vec_seen <= 1'b0;
      vec_val <= 16'h0;
      wait_r <= 8'h0;
    end
    else
    begin
      vec_ack <= 1'b0;
      vec_seen <= 1'b0;
      if (irq_req_r && !vec_ack)
      begin
        if (wait_r == 8'h0)
        begin
          vec_seen <= 1'b1;
          vec_val <= irq_vector;
        end
        wait_r <= wait_r + 8'h1;
        if (wait_r == ack_wait)
          vec_ack <= 1'b1;
      end
      else
        wait_r <= 8'h0;
    end
  end
endmodule

// file: verification/tb.sv
// self-checking bench for the vector dispatch block
// assumes the core model answers presented vectors
`timescale 1ns/1ps
`include "ivd_defines.svh"
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [`IVD_NSRC-1:0] src_req = '0;
  logic [7:0] ack_wait = 8'h0;
  logic [31:0] prdata_r, rv;
  logic pready_r, pslverr_r, irq_req_r, irq_out_r, vec_ack, vec_seen, sh;
  logic [15:0] irq_vector, vec_val;
  logic [33:0] rd_q[$];
  logic [15:0] vec_q[$];
  logic [39:0] en;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #12.5 pclk = ~pclk;
  ivd_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
    .pready_r(pready_r), .pslverr_r(pslverr_r), .src_req(src_req), .irq_req_r(irq_req_r),
    .irq_vector(irq_vector), .vec_ack(vec_ack), .irq_out_r(irq_out_r));
  ivd_core_model core (.pclk(pclk), .presetn(presetn), .irq_req_r(irq_req_r),
    .irq_vector(irq_vector), .vec_ack(vec_ack), .ack_wait(ack_wait), .vec_seen(vec_seen),
    .vec_val(vec_val));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // answers are compared in arrival order against the queued notes
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      fail_count++;
      results();
    end
    else
    begin
      if (psel && penable && pready_r === 1'b1)
      begin
        chk("pslverr", {31'h0, pslverr_r}, {31'h0, rd_q[0][32]});
        if (rd_q[0][33])
          chk("prdata", prdata_r, rd_q[0][31:0]);
        void'(rd_q.pop_front());
      end
      if (vec_seen === 1'b1)
        chk("vector", {16'h0, vec_val}, {16'h0, vec_q.pop_front()});
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [33:0] e);
    int n;
    rd_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready_r !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err = 1'b0);
    apb(1'b1, a, d, {1'b0, err, 32'h0});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
    apb(1'b0, a, 32'h0, {1'b1, err, e});
  endtask
  task automatic pulse(input int i);
    @(posedge pclk);
    src_req <= `IVD_NSRC'(1) << i;
    @(posedge pclk);
    src_req <= '0;
  endtask
  task automatic wait_seen();
    int n;
    n = 0;
    while (vec_seen !== 1'b1 && n < 80)
    begin
      @(posedge pclk);
      n++;
    end
    chk("presented", {31'h0, vec_seen}, 32'h1);
  endtask
  function automatic logic [39:0] en_of(input int i);
    if (i < 6) return {`IVD_OFS_NMC, 32'h1 << i};
    if (i < 11) return {`IVD_OFS_EN1, 32'h1 << (i - 6)};
    if (i < 14) return {`IVD_OFS_EN1, 32'h20};
    if (i < 17) return {`IVD_OFS_EN2, 32'h1 << (i - 14)};
    if (i < 21) return {`IVD_OFS_EN2, 32'h8};
    return {`IVD_OFS_EN2, 32'h10 << (i - 21)};
  endfunction
  function automatic logic [15:0] vec_of(input int i);
    if (i < 6) return 16'h0073;
    if (i < 11) return 16'h0003 + 16'(8 * (i - 6));
    if (i < 14) return 16'h002b;
    if (i < 17) return 16'h0033 + 16'(8 * (i - 14));
    if (i < 21) return 16'h004b;
    return 16'h0053 + 16'(8 * (i - 21));
  endfunction
  // ----
  // scenarios
  // ----
  initial
  begin
    void'($urandom(32'h2f68));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 7; a++)
      rd(8'(4 * a), 32'h0);
    // the table register follows index 0 from the first edge, so idle shows the nmi vector
    rd(`IVD_OFS_VSTAT, 32'h00100073);
    rv = $urandom();
    wr(`IVD_OFS_EN1, rv);
    rd(`IVD_OFS_EN1, {26'h0, rv[5:0]});
    wr(`IVD_OFS_EN1, 32'h0);
    rd(8'h20, 32'h0, 1'b1);
    wr(`IVD_OFS_VSTAT, 32'h1, 1'b1);
    for (int i = 0; i < `IVD_NSRC; i++)
    begin
      en = en_of(i);
      sh = i < 6 || (i > 10 && i < 14) || (i > 16 && i < 21);
      ack_wait <= sh ? 8'h28 : 8'($urandom_range(3));
      pulse(i);
      repeat (6) @(posedge pclk);
      chk("gated", {31'h0, irq_req_r}, 32'h0);
      rd(`IVD_OFS_PEND, 32'h1 << i);
      vec_q.push_back(vec_of(i));
      wr(en[39:32], en[31:0]);
      wait_seen();
      if (sh)
      begin
        rd(`IVD_OFS_PEND, 32'h1 << i);
        wr(`IVD_OFS_PEND, 32'h1 << i);
      end
      repeat (8) @(posedge pclk);
      rd(`IVD_OFS_PEND, 32'h0);
      wr(en[39:32], 32'h0);
    end
    // overrun, mask and vector taken events on the level output
    wr(`IVD_OFS_ISTAT, 32'h7);
    rd(`IVD_OFS_ISTAT, 32'h0);
    wr(`IVD_OFS_IMASK, 32'h3);
    pulse(7);
    pulse(7);
    rd(`IVD_OFS_ISTAT, 32'h2);
    chk("irq_out", {31'h0, irq_out_r}, 32'h1);
    wr(`IVD_OFS_IMASK, 32'h1);
    wr(`IVD_OFS_PEND, 32'h80);
    repeat (2) @(posedge pclk);
    chk("irq_out", {31'h0, irq_out_r}, 32'h0);
    ack_wait <= 8'h0;
    wr(`IVD_OFS_EN1, 32'h1);
    vec_q.push_back(16'h0003);
    pulse(6);
    wait_seen();
    repeat (4) @(posedge pclk);
    chk("irq_out", {31'h0, irq_out_r}, 32'h1);
    wr(`IVD_OFS_ISTAT, 32'h7);
    repeat (2) @(posedge pclk);
    chk("irq_out", {31'h0, irq_out_r}, 32'h0);
    // divider overflow in normal mode, reload f0 gives a short period
    ack_wait <= 8'h28;
    vec_q.push_back(16'h002b);
    wr(`IVD_OFS_EN1, 32'h20);
    wr(`IVD_OFS_FDC, 32'h0000f003);
    wait_seen();
    wr(`IVD_OFS_FDC, 32'h0);
    rd(`IVD_OFS_FDC, 32'h4);
    rd(`IVD_OFS_ISTAT, 32'h4);
    rd(`IVD_OFS_PEND, 32'h1000);
    wr(`IVD_OFS_FDC, 32'h4);
    wr(`IVD_OFS_PEND, 32'h1000);
    repeat (4) @(posedge pclk);
    chk("irq_req", {31'h0, irq_req_r}, 32'h0);
    // fractional mode with step ff must not raise the normal-mode overflow
    wr(`IVD_OFS_FDC, 32'h0000ff01);
    repeat (4) @(posedge pclk);
    rd(`IVD_OFS_FDC, 32'h0000ff01);
    rd(`IVD_OFS_PEND, 32'h0);
    wr(`IVD_OFS_FDC, 32'h0);
    results();
  end
endmodule
